// >>> src/cardbus_cfg_regs.svh
// register offsets, fixed values and reset values of the bridge header slice
`ifndef CARDBUS_CFG_REGS_SVH
`define CARDBUS_CFG_REGS_SVH
// ----------------------------------------------------------------------
// configuration byte offsets
// ----------------------------------------------------------------------
`define OFS_CACHE_LINE   8'h0C
`define OFS_TENURE       8'h0D
`define OFS_HEADER_KIND  8'h0E
`define OFS_SELF_TEST    8'h0F
`define OFS_WIN_BASE     8'h10
`define OFS_CAP_PTR      8'h14
`define OFS_PM_CAP       8'hA0
`define OFS_PM_CSR       8'hA4
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define POS_EXT_REGION   7
`define POS_WIN_BASE_LSB 12
`define POS_LEGACY_SEL   11
// ----------------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------------
`define RST_CACHE_LINE   8'h00
`define RST_TENURE       8'h00
`define VAL_HEADER_KIND  8'h82
`define VAL_SELF_TEST    8'h00
`define RST_WIN_BASE     20'h00000
`define VAL_CAP_PTR      8'hA0
`define TENURE_SATURATE  8'hFF
`endif

// >>> src/cardbus_cfg_pkg.sv
// types shared by the bridge configuration header slice
package cardbus_cfg_pkg;

  // number of bridge functions the state is built for
  localparam int MAX_FUNC = 2;

  // whole state of the header slice, registered as one word
  typedef struct packed {
    logic [MAX_FUNC-1:0][7:0]  cacheLine;
    logic [MAX_FUNC-1:0][7:0]  tenure;
    logic [MAX_FUNC-1:0][19:0] winBase;
    logic [MAX_FUNC-1:0][7:0]  latCnt;
    logic [MAX_FUNC-1:0]       latExp;
    logic [MAX_FUNC-1:0]       termReq;
    logic [MAX_FUNC-1:0]       sockHit;
    logic [MAX_FUNC-1:0]       legacyHit;
    logic [31:0]               rdData;
    logic                      ack;
    logic                      extSel;
    logic                      pmSel;
  } cfg_state_t;

endpackage

// >>> src/cardbus_bridge_config_header.sv
// configuration header slice 0Ch..14h of a two-function card bridge
//
// Overview of operation
// - cache line size: 8-bit read/write byte per function, reset to zero
// - tenure counter clears when the function starts a frame, counts each busy clock up to FFh
// - count reaching the limit while busy ends transfer once grant is gone
// - each function owns its own 8-bit read/write tenure limit
// - header kind byte always reads 82h in both functions
// - bytes up to 7Fh standard header; 80h..FFh handed to extension logic
// - self-test byte is read-only and always zero
// - window base stores written bits 31..12, 4-Kbyte aligned
// - window base bits 11..0 ignore writes and read zero
// - writing all ones to window base reads back FFFFF000h
// - window offset 000h socket registers, 800h legacy card register set
// - each function owns a separate window base
// - capability pointer is read-only and reads A0h
// - power-management dwords at A0h and A4h are flagged for their owner
`timescale 1ns/100ps
`include "cardbus_cfg_regs.svh"

module cardbus_bridge_config_header #(
  parameter int NUM_FUNC = 2
) (
  // clock and reset
  input  wire logic                                      sys_clk,
  input  wire logic                                      arst_n,
  // configuration cycles from the bus target unit
  input  wire logic                                      cfgReq,
  input  wire logic                                      cfgWr,
  input  wire logic                                      cfgFunc,
  input  wire logic [7:2]                                cfgAddr,
  input  wire logic [3:0]                                cfgBe,
  input  wire logic [31:0]                               cfgWrData,
  output logic                                           cfgAck,
  output logic      [31:0]                               cfgRdData,
  output logic                                           cfgExtSel,
  output logic                                           cfgPmSel,
  // initiator activity per function
  input  wire logic [cardbus_cfg_pkg::MAX_FUNC-1:0]      frameStart,
  input  wire logic [cardbus_cfg_pkg::MAX_FUNC-1:0]      initBusy,
  input  wire logic                                      gntN,
  output logic      [cardbus_cfg_pkg::MAX_FUNC-1:0]      tenureExpired,
  output logic      [cardbus_cfg_pkg::MAX_FUNC-1:0]      termReq,
  // memory cycles to be matched against the windows
  input  wire logic                                      memReq,
  input  wire logic [31:0]                               memAddr,
  output logic      [cardbus_cfg_pkg::MAX_FUNC-1:0]      sockRegHit,
  output logic      [cardbus_cfg_pkg::MAX_FUNC-1:0]      legacyRegHit
);

  // ----------------------------------------------------------------------
  // elaboration checks and local constants
  // ----------------------------------------------------------------------
  // one function is the least, and the packed state holds no more than the package count
  if (NUM_FUNC < 1 || NUM_FUNC > cardbus_cfg_pkg::MAX_FUNC)
  begin : g_bad_func
    $error("NUM_FUNC must lie between 1 and the packaged function count");
  end

  localparam logic [7:0] OfsCache = `OFS_CACHE_LINE;
  localparam logic [7:0] OfsBase  = `OFS_WIN_BASE;
  localparam logic [7:0] OfsCap   = `OFS_CAP_PTR;
  localparam logic [7:0] OfsPmCap = `OFS_PM_CAP;
  localparam logic [7:0] OfsPmCsr = `OFS_PM_CSR;
  localparam int         BaseLsb  = `POS_WIN_BASE_LSB;

  cardbus_cfg_pkg::cfg_state_t st_ff;
  cardbus_cfg_pkg::cfg_state_t nxt_st;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic fnOk;
    logic isWr;
    logic isRd;
    fnOk   = 1'b0;
    isWr   = 1'b0;
    isRd   = 1'b0;
    nxt_st = st_ff;
    // a missing function still answers, with zeros, so the bus never hangs
    nxt_st.ack    = cfgReq;
    nxt_st.rdData = 32'h00000000;
    // extension region select; its dwords live outside, so reads give zero
    nxt_st.extSel = cfgReq && cfgAddr[`POS_EXT_REGION];
    nxt_st.pmSel  = cfgReq && (cfgAddr == OfsPmCap[7:2] || cfgAddr == OfsPmCsr[7:2]);
    for (int f = 0; f < cardbus_cfg_pkg::MAX_FUNC; f++)
    begin
      fnOk = (f < NUM_FUNC) && (cfgFunc == f[0]);
      isWr = cfgReq && cfgWr && fnOk;
      isRd = cfgReq && !cfgWr && fnOk;
      if (isWr && cfgAddr == OfsCache[7:2] && cfgBe[0])
        nxt_st.cacheLine[f] = cfgWrData[7:0];
      if (isWr && cfgAddr == OfsCache[7:2] && cfgBe[1])
        nxt_st.tenure[f] = cfgWrData[15:8];
      // only bits 31..12 are stored; lane 0 has no storage behind it
      // an all-ones write therefore reads back FFFFF000h
      if (isWr && cfgAddr == OfsBase[7:2])
      begin
        if (cfgBe[1])
          nxt_st.winBase[f][3:0] = cfgWrData[15:12];
        if (cfgBe[2])
          nxt_st.winBase[f][11:4] = cfgWrData[23:16];
        if (cfgBe[3])
          nxt_st.winBase[f][19:12] = cfgWrData[31:24];
      end
      // read-only bytes have no write path at all
      if (isRd && cfgAddr == OfsCache[7:2])
        // self-test byte is hard-wired to zero
        nxt_st.rdData = {`VAL_SELF_TEST, `VAL_HEADER_KIND, st_ff.tenure[f],
                         st_ff.cacheLine[f]};
      if (isRd && cfgAddr == OfsBase[7:2])
        nxt_st.rdData = {st_ff.winBase[f], 12'h000};
      if (isRd && cfgAddr == OfsCap[7:2])
        nxt_st.rdData = {24'h000000, `VAL_CAP_PTR};

      // the counter stops at FFh so a long transfer never wraps back under the limit
      // tenure counter restart and count
      if (frameStart[f])
        nxt_st.latCnt[f] = 8'h00;
      else if (initBusy[f] && st_ff.latCnt[f] != `TENURE_SATURATE)
        nxt_st.latCnt[f] = st_ff.latCnt[f] + 8'h01;
      // expiry and termination once grant is withdrawn
      nxt_st.latExp[f]  = initBusy[f] && !frameStart[f] &&
                          (st_ff.latCnt[f] >= st_ff.tenure[f]);
      nxt_st.termReq[f] = nxt_st.latExp[f] && gntN;

      // a base of zero still decodes; memory-space enable is handled elsewhere
      // window decode: bit 11 splits socket block from legacy set
      nxt_st.sockHit[f]   = (f < NUM_FUNC) && memReq &&
                            memAddr[31:BaseLsb] == st_ff.winBase[f] &&
                            !memAddr[`POS_LEGACY_SEL];
      // each function matches only its own base
      nxt_st.legacyHit[f] = (f < NUM_FUNC) && memReq &&
                            memAddr[31:BaseLsb] == st_ff.winBase[f] &&
                            memAddr[`POS_LEGACY_SEL];
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // stored bytes return to reset values, answers and hits drop at once
      st_ff           <= '0;
      st_ff.cacheLine <= {cardbus_cfg_pkg::MAX_FUNC{`RST_CACHE_LINE}};
      st_ff.tenure    <= {cardbus_cfg_pkg::MAX_FUNC{`RST_TENURE}};
      st_ff.winBase   <= {cardbus_cfg_pkg::MAX_FUNC{`RST_WIN_BASE}};
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state flip-flops
  assign cfgAck        = st_ff.ack;
  assign cfgRdData     = st_ff.rdData;
  assign cfgExtSel     = st_ff.extSel;
  assign cfgPmSel      = st_ff.pmSel;
  assign tenureExpired = st_ff.latExp;
  assign termReq       = st_ff.termReq;
  assign sockRegHit    = st_ff.sockHit;
  assign legacyRegHit  = st_ff.legacyHit;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_ack_follows_req : assert property (cfgReq |=> cfgAck)
    else $error("configuration request not acknowledged next cycle");

  a_header_bytes_fixed : assert property (
    (cfgReq && !cfgWr && !cfgFunc && cfgAddr == OfsCache[7:2])
    |=> cfgRdData[31:16] == 16'h0082)
    else $error("header kind or self-test byte read wrong");

  a_selftest_zero : assert property (
    (cfgReq && !cfgWr && cfgAddr == OfsCache[7:2]) |=> cfgRdData[31:24] == 8'h00)
    else $error("self-test byte not zero");

  // write-then-read checks allow for the idle cycle the host leaves between
  // accesses, and require it to be idle so no other write slips in
  a_cache_line_write : assert property (
    (cfgReq && cfgWr && !cfgFunc && cfgAddr == OfsCache[7:2] && cfgBe[0])
    ##1 !cfgReq ##1 (cfgReq && !cfgWr && !cfgFunc && cfgAddr == OfsCache[7:2])
    |=> cfgRdData[7:0] == $past(cfgWrData[7:0], 3))
    else $error("cache line size did not read back");

  a_base_low_zero : assert property (
    (cfgReq && !cfgWr && cfgAddr == OfsBase[7:2]) |=> cfgRdData[11:0] == 12'h000)
    else $error("window base low bits not zero");

  a_base_all_ones : assert property (
    (cfgReq && cfgWr && cfgBe == 4'hF && cfgAddr == OfsBase[7:2] &&
     cfgWrData == 32'hFFFFFFFF && !cfgFunc)
    ##1 !cfgReq ##1 (cfgReq && !cfgWr && !cfgFunc && cfgAddr == OfsBase[7:2])
    |=> cfgRdData == 32'hFFFFF000)
    else $error("window base sizing read wrong");

  a_cap_ptr_fixed : assert property (
    (cfgReq && !cfgWr && !cfgFunc && cfgAddr == OfsCap[7:2])
    |=> cfgRdData == 32'h000000A0)
    else $error("capability pointer read wrong");

  a_ro_write_kept : assert property (
    (cfgReq && cfgWr && cfgAddr == OfsCap[7:2])
    |=> st_ff.cacheLine == $past(st_ff.cacheLine) && st_ff.tenure == $past(st_ff.tenure)
        && st_ff.winBase == $past(st_ff.winBase))
    else $error("read-only write changed stored state");

  a_ext_region_sel : assert property (
    cfgReq |=> cfgExtSel == $past(cfgAddr[`POS_EXT_REGION]))
    else $error("extension select does not follow address");

  a_pm_dword_sel : assert property (
    (cfgReq && cfgAddr == OfsPmCsr[7:2]) |=> cfgPmSel && cfgExtSel)
    else $error("power management dword not selected");

  a_quiet_no_req : assert property (
    !cfgReq |=> !cfgAck && !cfgExtSel && !cfgPmSel && cfgRdData == 32'h00000000)
    else $error("answer raised without a request");

  a_tenure_write : assert property (
    (cfgReq && cfgWr && !cfgFunc && cfgAddr == OfsCache[7:2] && cfgBe[1])
    ##1 !cfgReq ##1 (cfgReq && !cfgWr && !cfgFunc && cfgAddr == OfsCache[7:2])
    |=> cfgRdData[15:8] == $past(cfgWrData[15:8], 3))
    else $error("tenure limit did not read back");

  a_ext_reads_zero : assert property (
    (cfgReq && !cfgWr && cfgAddr[`POS_EXT_REGION]) |=> cfgRdData == 32'h00000000)
    else $error("extension dword answered with data");

  a_no_hit_idle : assert property (
    !memReq |=> sockRegHit == '0 && legacyRegHit == '0)
    else $error("window hit without a memory cycle");

  // per-function counter, termination, stored-byte and window checks
  for (genvar g = 0; g < NUM_FUNC; g++)
  begin : g_func_chk
    a_count_restart : assert property (
      frameStart[g] ##1 (initBusy[g] && !frameStart[g]) |=> st_ff.latCnt[g] == 8'h01)
      else $error("tenure counter did not restart at frame");

    a_term_on_grant : assert property (
      (initBusy[g] && !frameStart[g] && gntN && st_ff.latCnt[g] >= st_ff.tenure[g])
      |=> termReq[g] && tenureExpired[g])
      else $error("expired transfer not terminated after grant loss");

    a_no_term_granted : assert property (
      !gntN |=> !termReq[g])
      else $error("termination while grant still held");

    a_window_split : assert property (
      (memReq && memAddr[31:BaseLsb] == st_ff.winBase[g])
      |=> sockRegHit[g] != legacyRegHit[g])
      else $error("window hit not split by offset 800h");

    a_count_step : assert property (
      (initBusy[g] && !frameStart[g] && st_ff.latCnt[g] != `TENURE_SATURATE)
      |=> st_ff.latCnt[g] == $past(st_ff.latCnt[g]) + 8'h01)
      else $error("tenure counter did not advance");

    a_idle_no_expiry : assert property (
      !initBusy[g] |=> !tenureExpired[g] && !termReq[g])
      else $error("expiry raised with no transfer in progress");

    a_cfg_bytes_kept : assert property (
      !(cfgReq && cfgWr && cfgFunc == (g != 0) && cfgAddr == OfsCache[7:2])
      |=> $stable(st_ff.cacheLine[g]) && $stable(st_ff.tenure[g]))
      else $error("cache line or tenure byte changed without a write");

    a_base_read_back : assert property (
      (cfgReq && !cfgWr && cfgFunc == (g != 0) && cfgAddr == OfsBase[7:2])
      |=> cfgRdData[31:BaseLsb] == $past(st_ff.winBase[g]))
      else $error("window base read does not match its own function");
  end

  // ----------------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------------
  c_base_sizing : cover property (
    (cfgReq && cfgWr && cfgAddr == OfsBase[7:2] && cfgWrData == 32'hFFFFFFFF)
    ##1 !cfgReq ##1 (cfgReq && !cfgWr && cfgAddr == OfsBase[7:2]));
  c_tenure_term : cover property (frameStart[0] ##[1:20] termReq[0]);
  c_legacy_hit : cover property (legacyRegHit[NUM_FUNC-1]);
  c_pm_access : cover property (cfgPmSel);
  c_func1_base : cover property (cfgReq && cfgWr && cfgFunc && cfgAddr == OfsBase[7:2]);

endmodule

// >>> testbench/cfg_host_model.sv
// host-side model that issues configuration cycles to the header slice
`timescale 1ns/100ps
module cfg_host_model (
  // clock
  input  wire logic        sys_clk,
  // request side
  output logic             cfgReq,
  output logic             cfgWr,
  output logic             cfgFunc,
  output logic [7:2]       cfgAddr,
  output logic [3:0]       cfgBe,
  output logic [31:0]      cfgWrData,
  // answer side
  input  wire logic        cfgAck,
  input  wire logic [31:0] cfgRdData,
  input  wire logic        cfgExtSel,
  input  wire logic        cfgPmSel
);
  // idle bus at time zero
  initial
  begin
    cfgReq = 1'b0;
    cfgWr = 1'b0;
    cfgFunc = 1'b0;
    cfgAddr = 6'h00;
    cfgBe = 4'h0;
    cfgWrData = 32'h00000000;
  end

  // one access: request held over one edge, answer taken in the following cycle
  task automatic access(input logic wr, input logic fn, input logic [7:0] byteAddr,
    input logic [3:0] be, input logic [31:0] wd, output logic [34:0] ans);
    begin
      @(posedge sys_clk);
      #1;
      cfgReq = 1'b1;
      cfgWr = wr;
      cfgFunc = fn;
      cfgAddr = byteAddr[7:2];
      cfgBe = be;
      cfgWrData = wd;
      @(posedge sys_clk);
      #1;
      ans = {cfgAck, cfgExtSel, cfgPmSel, cfgRdData};
      cfgReq = 1'b0;
      // address and write data lines change so a stale value never passes for fresh data
      cfgWrData = ~cfgWrData;
      cfgAddr = ~cfgAddr;
    end
  endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the bridge configuration header slice
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cfgReq, cfgWr, cfgFunc, cfgAck, cfgExtSel, cfgPmSel, gntN, memReq;
  logic [7:2]  cfgAddr;
  logic [3:0]  cfgBe;
  logic [31:0] cfgWrData, cfgRdData, memAddr;
  logic [1:0]  frameStart, initBusy, tenureExpired, termReq, sockRegHit, legacyRegHit;
  int          fails = 0;
  int          checks_done = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  cardbus_bridge_config_header dut (.sys_clk, .arst_n, .cfgReq, .cfgWr, .cfgFunc, .cfgAddr,
    .cfgBe, .cfgWrData, .cfgAck, .cfgRdData, .cfgExtSel, .cfgPmSel, .frameStart, .initBusy,
    .gntN, .tenureExpired, .termReq, .memReq, .memAddr, .sockRegHit, .legacyRegHit);

  cfg_host_model host (.sys_clk, .cfgReq, .cfgWr, .cfgFunc, .cfgAddr, .cfgBe, .cfgWrData,
    .cfgAck, .cfgRdData, .cfgExtSel, .cfgPmSel);

  task automatic give_verdict();
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // one compare for every kind of result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      checks_done++;
      if (got !== exp)
      begin
        fails++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // config access, then check acknowledge, data and region flags {ext, pm}
  task automatic rw(input logic wr, input logic fn, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] wd, input logic [31:0] exp, input logic [1:0] flags);
    logic [34:0] ans;
    begin
      host.access(wr, fn, a, be, wd, ans);
      chk("cfg ack", 32'h00000001, {31'h0, ans[34]});
      chk("cfg data", exp, ans[31:0]);
      chk("cfg flags", {30'h0, flags}, {30'h0, ans[33:32]});
    end
  endtask

  // memory cycle, hits show one cycle later
  task automatic mem(input logic [31:0] a, input logic [1:0] sock, input logic [1:0] leg);
    begin
      @(posedge sys_clk);
      #1;
      memReq = 1'b1;
      memAddr = a;
      @(posedge sys_clk);
      #1;
      memReq = 1'b0;
      memAddr = ~a;
      chk("socket hit", {30'h0, sock}, {30'h0, sockRegHit});
      chk("legacy hit", {30'h0, leg}, {30'h0, legacyRegHit});
    end
  endtask

  // watchdog, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #20000;
    fails++;
    give_verdict();
  end

  initial
  begin
    frameStart = 2'h0;
    initBusy = 2'h0;
    gntN = 1'b0;
    memReq = 1'b0;
    memAddr = 32'h00000000;
    repeat (6) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      rw(0, f[0], 8'h0C, 4'hF, 32'h0, 32'h00820000, 2'b00);
      rw(0, f[0], 8'h10, 4'hF, 32'h0, 32'h00000000, 2'b00);
      rw(0, f[0], 8'h14, 4'hF, 32'h0, 32'h000000A0, 2'b00);
    end
    rw(1, 0, 8'h0C, 4'hF, 32'h12343C5A, 32'h0, 2'b00);
    rw(0, 0, 8'h0C, 4'hF, 32'h0, 32'h00823C5A, 2'b00);
    rw(0, 1, 8'h0C, 4'hF, 32'h0, 32'h00820000, 2'b00);
    rw(1, 0, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0, 2'b00);
    rw(0, 0, 8'h10, 4'hF, 32'h0, 32'hFFFFF000, 2'b00);
    rw(1, 1, 8'h10, 4'hE, 32'h12345678, 32'h0, 2'b00);
    rw(0, 1, 8'h10, 4'hF, 32'h0, 32'h12345000, 2'b00);
    rw(1, 0, 8'h14, 4'hF, 32'hFFFFFFFF, 32'h0, 2'b00);
    rw(0, 0, 8'h14, 4'hF, 32'h0, 32'h000000A0, 2'b00);
    rw(0, 0, 8'h7C, 4'hF, 32'h0, 32'h0, 2'b00);
    rw(0, 0, 8'h80, 4'hF, 32'h0, 32'h0, 2'b10);
    rw(0, 1, 8'hA0, 4'hF, 32'h0, 32'h0, 2'b11);
    rw(0, 0, 8'hA4, 4'hF, 32'h0, 32'h0, 2'b11);
    mem(32'hFFFFF004, 2'b01, 2'b00);
    mem(32'hFFFFF800, 2'b00, 2'b01);
    mem(32'h12345FFC, 2'b00, 2'b10);
    mem(32'h12346000, 2'b00, 2'b00);
    // function 0 limit of two clocks, function 1 stays idle
    rw(1, 0, 8'h0C, 4'h2, 32'h00000200, 32'h0, 2'b00);
    @(posedge sys_clk);
    #1;
    frameStart = 2'b01;
    initBusy = 2'b01;
    @(posedge sys_clk);
    #1;
    frameStart = 2'b00;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("expired early", 32'h0, {30'h0, tenureExpired});
    @(posedge sys_clk);
    #1;
    chk("expired", 32'h1, {30'h0, tenureExpired});
    chk("term with grant", 32'h0, {30'h0, termReq});
    gntN = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("term", 32'h1, {30'h0, termReq});
    initBusy = 2'b00;
    gntN = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("expired idle", 32'h0, {30'h0, tenureExpired});
    // mid-run reset: stored bytes and window base return to zero
    arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    rw(0, 0, 8'h0C, 4'hF, 32'h0, 32'h00820000, 2'b00);
    rw(0, 1, 8'h10, 4'hF, 32'h0, 32'h00000000, 2'b00);
    give_verdict();
  end
endmodule
